// File: core/dtt_pkg.sv
// constants and encodings for the debug trigger and trace control block
// assumes one APB master and CPU bus signals on the same clock
// How it works
// - four-bit mode field picks nine modes
// - start select picks begin or end trace
// - address entries normally, data bytes in event modes
// - direction check adds read/write as input
// - opcode qualify waits for tagged opcode execution
// - event modes bypass opcode qualification
// - begin trace fills after trigger, stops full
// - end trace fills circularly, stops at trigger
// - circular fill keeps eight newest entries
// - arm write starts run, clears flags, count
// - writing arm or enable zero stops run
// - A-only: address equals A sets A, triggers
// - A-or-B: either match sets its flag
// - A-then-B: B counts only after A flag
// - event B: B match sets B, triggers
// - A-then-event-B: A first, then B triggers
// - A-and-B data: address A, data byte B
// - data bus chosen by A direction setting
// - A-and-not-B: address A, data differs B
// - inside range A to B sets both
// - outside range sets A below, B above
// - event modes always begin trace, trigger first
// - break request at trigger or fill
package dtt_pkg;
  // ****************************************
  // register offsets
  // ****************************************
  localparam logic [7:0] OFS_COMP_A  = 8'h00; // comparator a value
  localparam logic [7:0] OFS_COMP_B  = 8'h04; // comparator b value
  localparam logic [7:0] OFS_CTRL    = 8'h08; // debug_control_reg
  localparam logic [7:0] OFS_TRIG    = 8'h0C; // trigger_control_reg
  localparam logic [7:0] OFS_STATUS  = 8'h10; // debug_status_reg
  localparam logic [7:0] OFS_FIFO_HI = 8'h14; // trace entry high byte
  localparam logic [7:0] OFS_FIFO_LO = 8'h18; // trace entry low, advances
  // ****************************************
  // field positions
  // ****************************************
  localparam int CTL_EN    = 7; // debug_unit_enable
  localparam int CTL_ARM   = 6; // arm bit
  localparam int CTL_TAG   = 5; // break type, stored only
  localparam int CTL_BRKEN = 4; // break request enable
  localparam int CTL_RWA   = 3; // a_direction_value, 1 read
  localparam int CTL_A_DIRECTION_CHECK_EN = 2; // a_direction_check_en
  localparam int CTL_RWB   = 1; // b_direction_value, 1 read
  localparam int CTL_B_DIRECTION_CHECK_EN = 0; // b_direction_check_en
  localparam int TRG_SEL   = 7; // opcode_qualify_select
  localparam int TRG_BEGIN = 6; // begin trace select
  localparam int ST_RUN_ACTIVE_FLAG   = 7; // run_active_flag
  localparam int ST_AF     = 6; // match_a_flag
  localparam int ST_BF     = 5; // match_b_flag
  // ****************************************
  // reset values and counts
  // ****************************************
  localparam logic [15:0] RST_COMP = 16'h0000;
  localparam logic [7:0]  RST_REG  = 8'h00;
  localparam logic [3:0]  CNT_FULL = 4'h8; // eight entries
  localparam logic [3:0]  CNT_LAST = 4'h7;
  localparam int          FIFO_N   = 8;
  // trigger_mode_field encodings
  typedef enum logic [3:0] {
    MODE_A_ONLY  = 4'h0,
    MODE_A_OR_B  = 4'h1,
    MODE_A_THN_B = 4'h2,
    MODE_EV_B    = 4'h3,
    MODE_A_EV_B  = 4'h4,
    MODE_A_AND_D = 4'h5,
    MODE_A_NOT_D = 4'h6,
    MODE_INSIDE  = 4'h7,
    MODE_OUTSIDE = 4'h8
  } dtt_mode_e;
endpackage

// File: core/dtt_top.sv
// debug trigger and trace capture with an APB register slave
// assumes CPU bus, change-of-flow and pipe signals on I_CLK
`timescale 1ns/10ps
module dtt_top #(
  parameter int PIPE_DEPTH = 3 // tracking stages, at least 2
) (
  input  wire logic        I_CLK,
  input  wire logic        I_RST,
  input  wire logic        I_PSEL,
  input  wire logic        I_PENABLE,
  input  wire logic        I_PWRITE,
  input  wire logic [7:0]  I_PADDR,
  input  wire logic [31:0] I_PWDATA,
  output logic      [31:0] O_PRDATA,
  output logic             O_PREADY,
  output logic             O_PSLVERR,
  input  wire logic [15:0] I_CPU_ADDR,
  input  wire logic [7:0]  I_CPU_RDATA,
  input  wire logic [7:0]  I_CPU_WDATA,
  input  wire logic        I_CPU_RW,
  input  wire logic        I_CPU_CYCLE,
  input  wire logic        I_COF_VALID,
  input  wire logic [15:0] I_COF_ADDR,
  input  wire logic        I_PIPE_ADV,
  input  wire logic        I_PIPE_FLUSH,
  output logic             O_BREAK_REQ
);
  import dtt_pkg::*;

  // ****************************************
  // state
  // ****************************************
  logic [15:0] comp_a_q;          // comparator a
  logic [15:0] comp_b_q;          // comparator b
  logic [7:0]  ctrl_q;            // debug_control_reg bits
  logic [7:0]  trig_q;            // trigger_control_reg bits
  logic        run_q;             // run_active_flag
  logic        af_q;              // match_a_flag
  logic        bf_q;              // match_b_flag
  logic        seen_q;            // trigger seen in begin run
  logic [3:0]  cnt_q;             // entry_count_field
  logic [2:0]  wr_ptr_q;          // next slot to fill
  logic [2:0]  rd_ptr_q;          // read-out slot
  logic [15:0] fifo_q [FIFO_N];   // trace entries
  logic        pready_q;
  logic        brk_q;
  logic [31:0] prdata_q;
  logic        pslverr_q;

  // ****************************************
  // bus decode
  // ****************************************
  logic acc, done, wr, mapped, start, stop_wr;
  logic [31:0] rd_mux;
  // one wait state: answer comes the cycle after access starts
  assign acc    = I_PSEL && I_PENABLE && !pready_q;
  assign done   = I_PSEL && I_PENABLE && pready_q;
  assign wr     = done && I_PWRITE;
  assign mapped = (I_PADDR == OFS_COMP_A) || (I_PADDR == OFS_COMP_B) ||
                  (I_PADDR == OFS_CTRL) || (I_PADDR == OFS_TRIG) ||
                  (I_PADDR == OFS_STATUS) || (I_PADDR == OFS_FIFO_HI) ||
                  (I_PADDR == OFS_FIFO_LO);
  // arm needs the enable written in the same word
  assign start   = wr && (I_PADDR == OFS_CTRL) && I_PWDATA[CTL_ARM] &&
                   I_PWDATA[CTL_EN];
  assign stop_wr = wr && (I_PADDR == OFS_CTRL) &&
                   (!I_PWDATA[CTL_ARM] || !I_PWDATA[CTL_EN]);

  // ****************************************
  // mode decode and comparators
  // ****************************************
  dtt_mode_e mode;
  logic ev, beg, use_tag, rwa_ok, rwb_ok, eqa, eqb, deq;
  logic [7:0] dsel;
  assign mode    = dtt_mode_e'(trig_q[3:0]);
  assign ev      = (mode == MODE_EV_B) || (mode == MODE_A_EV_B);
  // event modes always begin trace
  assign beg     = trig_q[TRG_BEGIN] || ev;
  // software should not pair these, but hardware shields it anyway
  assign use_tag = trig_q[TRG_SEL] && !ev;
  // direction acts as an extra comparator input
  assign rwa_ok  = !ctrl_q[CTL_A_DIRECTION_CHECK_EN] ||
                   (I_CPU_RW == ctrl_q[CTL_RWA]);
  assign rwb_ok  = !ctrl_q[CTL_B_DIRECTION_CHECK_EN] ||
                   (I_CPU_RW == ctrl_q[CTL_RWB]);
  assign eqa     = I_CPU_ADDR == comp_a_q;
  assign eqb     = I_CPU_ADDR == comp_b_q;
  // write bus only when a checks for writes
  assign dsel    = (ctrl_q[CTL_A_DIRECTION_CHECK_EN] && !ctrl_q[CTL_RWA]) ?
                   I_CPU_WDATA : I_CPU_RDATA;
  assign deq     = dsel == comp_b_q[7:0];

  // raw hits per comparator before opcode tracking
  logic [1:0] hit;
  logic       live;
  assign live = run_q && I_CPU_CYCLE && !start;
  always_comb begin
    hit = 2'b00;
    if (live) begin
      unique case (mode)
        MODE_A_ONLY: hit = {1'b0, eqa && rwa_ok};
        MODE_A_OR_B, MODE_A_THN_B, MODE_A_EV_B: begin
          hit = {eqb && rwb_ok, eqa && rwa_ok};
        end
        MODE_EV_B: hit = {eqb && rwb_ok, 1'b0};
        MODE_A_AND_D: hit = {2{eqa && rwa_ok && deq}};
        MODE_A_NOT_D: hit = {2{eqa && rwa_ok && !deq}};
        MODE_INSIDE: begin
          // range test uses both direction checks
          hit = {2{(I_CPU_ADDR >= comp_a_q) && (I_CPU_ADDR <= comp_b_q)
                   && rwa_ok && rwb_ok}};
        end
        MODE_OUTSIDE: begin
          hit = {(I_CPU_ADDR > comp_b_q) && rwb_ok,
                 (I_CPU_ADDR < comp_a_q) && rwa_ok};
        end
        default: hit = 2'b00; // unused codes never trigger
      endcase
    end
  end

  // ****************************************
  // opcode tracking, one shift per comparator
  // ****************************************
  logic [1:0] tag_out, qual;
  genvar g;
  for (g = 0; g < 2; g++) begin : g_pipe
    logic [PIPE_DEPTH-1:0] stg_q; // tag travelling with the opcode
    // a flush drops tags whose opcodes were thrown away
    always_ff @(posedge I_CLK) begin
      if (I_RST || I_PIPE_FLUSH || !run_q) begin
        stg_q <= '0;
      end else if (I_PIPE_ADV) begin
        stg_q <= {stg_q[PIPE_DEPTH-2:0], hit[g]};
      end else begin
        stg_q[0] <= stg_q[0] | hit[g];
      end
    end
    // fires only when the tagged opcode leaves the pipe end
    assign tag_out[g] = I_PIPE_ADV && stg_q[PIPE_DEPTH-1] && run_q;
  end
  assign qual = use_tag ? tag_out : hit;

  // ****************************************
  // flag and trigger decision
  // ****************************************
  logic set_a, set_b, trig;
  always_comb begin
    set_a = qual[0];
    set_b = qual[1];
    trig  = 1'b0;
    unique case (mode)
      MODE_A_ONLY: trig = qual[0];
      MODE_A_OR_B, MODE_OUTSIDE: trig = |qual;
      MODE_A_THN_B, MODE_A_EV_B: begin
        // b only counts once a has been seen
        set_b = qual[1] && af_q;
        trig  = set_b;
      end
      MODE_EV_B: trig = qual[1];
      MODE_A_AND_D, MODE_A_NOT_D, MODE_INSIDE: trig = qual[0];
      default: trig = 1'b0;
    endcase
  end

  // ****************************************
  // trace storage control
  // ****************************************
  logic store, fill_end, trig_end;
  logic [15:0] entry;
  // event modes store the data byte, high byte zero
  assign entry = ev ? {8'h00, (I_CPU_RW ? I_CPU_RDATA : I_CPU_WDATA)}
                    : I_COF_ADDR;
  always_comb begin
    store = 1'b0;
    if (run_q && !start) begin
      if (ev) begin
        store = set_b && (trig || seen_q);
      end else if (beg) begin
        store = I_COF_VALID && seen_q;
      end else begin
        store = I_COF_VALID;
      end
    end
  end
  assign fill_end = run_q && beg && store && (cnt_q == CNT_LAST);
  assign trig_end = run_q && !beg && trig && !start;

  // run flag: arm starts, fill or trigger or a write ends
  always_ff @(posedge I_CLK) begin
    if (I_RST) begin
      run_q <= 1'b0;
    end else if (start) begin
      run_q <= 1'b1;
    end else if (stop_wr || fill_end || trig_end) begin
      run_q <= 1'b0;
    end
  end

  // begin runs remember that the trigger has passed
  always_ff @(posedge I_CLK) begin
    if (I_RST || start) begin
      seen_q <= 1'b0;
    end else if (run_q && trig) begin
      seen_q <= 1'b1;
    end
  end

  // flags: cleared by arming, otherwise sticky
  always_ff @(posedge I_CLK) begin
    if (I_RST) begin
      af_q <= 1'b0;
      bf_q <= 1'b0;
    end else if (start) begin
      af_q <= 1'b0;
      bf_q <= 1'b0;
    end else begin
      af_q <= af_q | set_a;
      bf_q <= bf_q | set_b;
    end
  end

  // count saturates at eight, pointer wraps over oldest entry
  always_ff @(posedge I_CLK) begin
    if (I_RST || start) begin
      cnt_q    <= 4'h0;
      wr_ptr_q <= 3'h0;
    end else if (store) begin
      wr_ptr_q <= wr_ptr_q + 3'h1;
      if (cnt_q != CNT_FULL) begin
        cnt_q <= cnt_q + 4'h1;
      end
    end
  end

  // entry array, cleared so reads before any run show zero
  always_ff @(posedge I_CLK) begin
    if (I_RST) begin
      for (int i = 0; i < FIFO_N; i++) begin
        fifo_q[i] <= 16'h0000;
      end
    end else if (store) begin
      fifo_q[wr_ptr_q] <= entry;
    end
  end

  // read-out pointer starts at slot zero, or at the write pointer when an end run triggers with eight entries
  always_ff @(posedge I_CLK) begin
    if (I_RST || start) begin
      rd_ptr_q <= 3'h0;
    end else if (trig_end) begin
      rd_ptr_q <= (cnt_q == CNT_FULL) ? wr_ptr_q : 3'h0;
    end else if (done && !I_PWRITE && (I_PADDR == OFS_FIFO_LO) &&
                 !run_q) begin
      // reads while armed would scramble order, so they hold
      rd_ptr_q <= rd_ptr_q + 3'h1;
    end
  end

  // break request pulse
  always_ff @(posedge I_CLK) begin
    if (I_RST) begin
      brk_q <= 1'b0;
    end else begin
      brk_q <= ctrl_q[CTL_BRKEN] && (trig_end || fill_end);
    end
  end

  // ****************************************
  // registers written by software
  // ****************************************
  // comparators and trigger setup are frozen while armed
  always_ff @(posedge I_CLK) begin
    if (I_RST) begin
      comp_a_q <= RST_COMP;
      comp_b_q <= RST_COMP;
      trig_q   <= RST_REG;
    end else if (wr && !ctrl_q[CTL_ARM]) begin
      if (I_PADDR == OFS_COMP_A) comp_a_q <= I_PWDATA[15:0];
      if (I_PADDR == OFS_COMP_B) comp_b_q <= I_PWDATA[15:0];
      if (I_PADDR == OFS_TRIG) trig_q <= {I_PWDATA[7:6], 2'b00,
                                           I_PWDATA[3:0]};
    end
  end

  // enable and arm always writable, rest only when disarmed
  always_ff @(posedge I_CLK) begin
    if (I_RST) begin
      ctrl_q <= RST_REG;
    end else if (wr && (I_PADDR == OFS_CTRL)) begin
      ctrl_q[CTL_EN]  <= I_PWDATA[CTL_EN];
      ctrl_q[CTL_ARM] <= start;
      if (!ctrl_q[CTL_ARM]) ctrl_q[5:0] <= I_PWDATA[5:0];
    end else if (fill_end || trig_end) begin
      ctrl_q[CTL_ARM] <= 1'b0; // run completion drops arm
    end
  end

  // ****************************************
  // read data and answer
  // ****************************************
  always_comb begin
    rd_mux = 32'h0000_0000;
    unique case (I_PADDR)
      OFS_COMP_A:  rd_mux = {16'h0000, comp_a_q};
      OFS_COMP_B:  rd_mux = {16'h0000, comp_b_q};
      OFS_CTRL:    rd_mux = {24'h000000, ctrl_q};
      OFS_TRIG:    rd_mux = {24'h000000, trig_q};
      OFS_STATUS:  rd_mux = {24'h000000, run_q, af_q, bf_q, 1'b0, cnt_q};
      OFS_FIFO_HI: rd_mux = {24'h000000, fifo_q[rd_ptr_q][15:8]};
      OFS_FIFO_LO: rd_mux = {24'h000000, fifo_q[rd_ptr_q][7:0]};
      default:     rd_mux = 32'h0000_0000; // unmapped reads zero
    endcase
  end

  // answer registered, data captured with it
  always_ff @(posedge I_CLK) begin
    if (I_RST) begin
      pready_q  <= 1'b0;
      pslverr_q <= 1'b0;
      prdata_q  <= 32'h0000_0000;
    end else begin
      pready_q  <= acc;
      pslverr_q <= acc && !mapped;
      prdata_q  <= (acc && !I_PWRITE) ? rd_mux : 32'h0000_0000;
    end
  end

  assign O_PREADY    = pready_q;
  assign O_PSLVERR   = pslverr_q;
  assign O_PRDATA    = prdata_q;
  assign O_BREAK_REQ = brk_q;

  // ****************************************
  // checks
  // ****************************************
  default clocking cb @(posedge I_CLK); endclocking
  default disable iff (I_RST);

  a_arm_clear: assert property (start |=> run_q && !af_q && !bf_q &&
    cnt_q == 4'h0) else $error("arm did not clear status");
  a_stop_write: assert property (stop_wr |=> !run_q)
    else $error("stop write left run active");
  a_begin_full: assert property (fill_end |=> !run_q &&
    cnt_q == CNT_FULL) else $error("begin run did not end full");
  a_end_trig: assert property (trig_end && !stop_wr |=> !run_q &&
    !ctrl_q[CTL_ARM]) else $error("end run did not stop");
  a_cnt_bound: assert property (cnt_q <= CNT_FULL)
    else $error("entry count above eight");
  a_flag_keep: assert property (af_q && !start |=> af_q)
    else $error("a flag dropped in run");
  a_break_pulse: assert property (ctrl_q[CTL_BRKEN] && trig_end
    |=> O_BREAK_REQ) else $error("no break at trigger");
  a_ev_untag: assert property (ev |-> qual == hit)
    else $error("event mode went through tracking");
  a_a_only: assert property (mode == MODE_A_ONLY && live &&
    !use_tag && eqa && rwa_ok |=> af_q) else $error("a match lost");
  a_range_in: assert property (mode == MODE_INSIDE && !use_tag &&
    hit[0] |=> af_q && bf_q) else $error("inside range flags");
  a_ready_once: assert property (pready_q |=> !pready_q)
    else $error("ready longer than one cycle");

  c_end_run: cover property (trig_end);
  c_full_run: cover property (fill_end);
  c_tag_fire: cover property (use_tag && |tag_out);
endmodule

// File: dv/dtt_cpu_model.sv
// cpu bus stand-in: address, data, direction, change-of-flow and pipe strobes
// assumes the bench calls one task at a time, all on the rising edge of i_clk
`timescale 1ns/10ps
module dtt_cpu_model (
  input  wire logic        i_clk,
  output logic      [15:0] o_addr,
  output logic      [7:0]  o_rdata,
  output logic      [7:0]  o_wdata,
  output logic             o_rw,
  output logic             o_cycle,
  output logic             o_cof,
  output logic      [15:0] o_cof_addr,
  output logic             o_adv
);
  // ****************************************
  // bus cycles
  // ****************************************
  // quiet bus at time zero
  initial begin
    {o_addr, o_rdata, o_wdata, o_rw, o_cycle, o_cof, o_cof_addr, o_adv} = '0;
  end
  // one valid bus cycle; after it the lines float, shown as the inverse
  // so a stale value can never pass for a fresh one
  task automatic cyc(input logic [15:0] a, input logic r, input logic [7:0] rd,
                     input logic [7:0] wd);
    @(posedge i_clk);
    o_addr  <= a;
    o_rw    <= r;
    o_rdata <= rd;
    o_wdata <= wd;
    o_cycle <= 1'b1;
    @(posedge i_clk);
    o_cycle <= 1'b0;
    o_addr  <= ~a;
    o_rw    <= ~r;
    o_rdata <= ~rd;
    o_wdata <= ~wd;
  endtask
  // change-of-flow address strobe, one cycle
  task automatic cof(input logic [15:0] a);
    @(posedge i_clk);
    o_cof      <= 1'b1;
    o_cof_addr <= a;
    @(posedge i_clk);
    o_cof      <= 1'b0;
    o_cof_addr <= ~a;
  endtask
  // one opcode leaves the pipe end
  task automatic adv;
    @(posedge i_clk);
    o_adv <= 1'b1;
    @(posedge i_clk);
    o_adv <= 1'b0;
  endtask
endmodule

// File: dv/tb_top.sv
// bench for the trigger and trace block: apb register tasks plus cpu model
// assumes one clock, sync active-high reset and an apb slave that may wait
`timescale 1ns/10ps
`define CHK(a, b) begin total_checks++; if ((a) !== (b)) begin miscompares++; \
  $display("unexpected at %0t: got %h want %h", $time, a, b); end end
module tb_top;
  import dtt_pkg::*;
  localparam int          PD = 3;            // pipe tracking depth under test
  localparam logic [31:0] Z  = 32'h00000000; // blank write data
  logic        clk, rst, psel, pen, pwr, rdy, err, brq, rw, cyc, cof, adv, e, fl;
  logic [7:0]  pa, rdt, wdt;
  logic [15:0] ca, cofa;
  logic [31:0] pwd, prd, q;
  int          miscompares, total_checks, brk, tn;
  // ****************************************
  // clock, design and partner
  // ****************************************
  initial clk = 1'b0;
  always #5 clk = ~clk;
  // break pulses counted per run
  always @(posedge clk) if (brq === 1'b1) brk++;
  dtt_top #(.PIPE_DEPTH(PD)) dut_u (
    .I_CLK(clk), .I_RST(rst), .I_PSEL(psel), .I_PENABLE(pen), .I_PWRITE(pwr),
    .I_PADDR(pa), .I_PWDATA(pwd), .O_PRDATA(prd), .O_PREADY(rdy), .O_PSLVERR(err),
    .I_CPU_ADDR(ca), .I_CPU_RDATA(rdt), .I_CPU_WDATA(wdt), .I_CPU_RW(rw),
    .I_CPU_CYCLE(cyc), .I_COF_VALID(cof), .I_COF_ADDR(cofa), .I_PIPE_ADV(adv),
    .I_PIPE_FLUSH(fl), .O_BREAK_REQ(brq));
  dtt_cpu_model cpu_u (
    .i_clk(clk), .o_addr(ca), .o_rdata(rdt), .o_wdata(wdt), .o_rw(rw), .o_cycle(cyc),
    .o_cof(cof), .o_cof_addr(cofa), .o_adv(adv));
  // ****************************************
  // tasks
  // ****************************************
  // one apb transfer; ready and data are taken at the rising edge that samples them
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    int n;
    n = 0;
    @(posedge clk);
    psel <= 1'b1;
    pwr  <= w;
    pa   <= a;
    pwd  <= d;
    @(posedge clk);
    pen <= 1'b1;
    do begin
      @(posedge clk);
      n++;
    end while (rdy !== 1'b1 && n < 50);
    q = prd;
    e = err;
    if (n >= 50) miscompares++;
    psel <= 1'b0;
    pen  <= 1'b0;
  endtask
  task automatic st(input logic [7:0] x);
    apb(1'b0, OFS_STATUS, Z);
    `CHK(q[7:0], x)
  endtask
  // high byte first: the low byte read advances the pointer
  task automatic ent(input logic [15:0] x);
    logic [7:0] h;
    apb(1'b0, OFS_FIFO_HI, Z);
    h = q[7:0];
    apb(1'b0, OFS_FIFO_LO, Z);
    `CHK({h, q[7:0]}, x)
  endtask
  // stop, program, then arm with enable in the same write
  task automatic arm(input logic [15:0] a, input logic [15:0] b, input logic [7:0] t,
                     input logic [7:0] c);
    apb(1'b1, OFS_CTRL, Z);
    apb(1'b1, OFS_COMP_A, {16'h0000, a});
    apb(1'b1, OFS_COMP_B, {16'h0000, b});
    apb(1'b1, OFS_TRIG, {24'h000000, t});
    apb(1'b1, OFS_CTRL, {24'h000000, c | 8'hC0});
    brk = 0;
  endtask
  task automatic te;
    $display("test %0d ended", tn);
    tn++;
  endtask
  task automatic end_of_test;
    $display("checks %0d miscompares %0d", total_checks, miscompares);
    if (miscompares == 0 && total_checks > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask
  // watchdog well beyond the under one thousand cycles the tests need
  initial begin
    repeat (20000) @(posedge clk);
    miscompares++;
    end_of_test;
  end
  // ****************************************
  // tests
  // ****************************************
  initial begin
    {rst, psel, pen, pwr, pa, pwd, fl, brk, tn, miscompares, total_checks} = '0;
    rst = 1'b1;
    repeat (10) @(posedge clk);
    rst <= 1'b0;
    // every register clear after reset, unmapped place refused
    for (int i = 0; i < 7; i++) begin
      apb(1'b0, 8'(4 * i), Z);
      `CHK(q, Z)
    end
    apb(1'b0, 8'h1C, Z);
    `CHK({e, q}, {1'b1, Z})
    te;
    // end trace, a only, break at the trigger
    arm(16'h1234, 16'h0000, 8'h00, 8'h10);
    cpu_u.cof(16'h4000);
    cpu_u.cof(16'h4001);
    cpu_u.cyc(16'h1235, 1'b1, 8'h00, 8'h00);
    cpu_u.cyc(16'h1234, 1'b1, 8'h00, 8'h00);
    st(8'h42);
    `CHK(brk, 1)
    ent(16'h4000);
    ent(16'h4001);
    te;
    // end trace wraps, oldest dropped
    arm(16'h1234, 16'h0000, 8'h00, 8'h00);
    for (int i = 0; i < 10; i++) cpu_u.cof(16'(16'h4010 + i));
    cpu_u.cyc(16'h1234, 1'b1, 8'h00, 8'h00);
    st(8'h48);
    for (int i = 0; i < 8; i++) ent(16'(16'h4012 + i));
    te;
    // begin trace with direction check, break on fill
    arm(16'h1234, 16'h0000, 8'h40, 8'h1C);
    cpu_u.cyc(16'h1234, 1'b0, 8'h00, 8'h00);
    st(8'h80);
    cpu_u.cyc(16'h1234, 1'b1, 8'h00, 8'h00);
    st(8'hC0);
    `CHK(brk, 0)
    for (int i = 0; i < 8; i++) cpu_u.cof(16'(16'h4020 + i));
    st(8'h48);
    `CHK(brk, 1)
    for (int i = 0; i < 8; i++) ent(16'(16'h4020 + i));
    te;
    // either comparator
    arm(16'h1234, 16'h5678, 8'h01, 8'h00);
    cpu_u.cyc(16'h5678, 1'b1, 8'h00, 8'h00);
    st(8'h20);
    te;
    // b counts only after a
    arm(16'h1234, 16'h5678, 8'h02, 8'h00);
    cpu_u.cyc(16'h5678, 1'b1, 8'h00, 8'h00);
    st(8'h80);
    cpu_u.cyc(16'h1234, 1'b1, 8'h00, 8'h00);
    st(8'hC0);
    cpu_u.cyc(16'h5678, 1'b1, 8'h00, 8'h00);
    st(8'h60);
    te;
    // event b with read check, end select ignored, data bytes stored
    arm(16'h1234, 16'h2000, 8'h03, 8'h03);
    cpu_u.cyc(16'h1234, 1'b1, 8'h00, 8'h00);
    cpu_u.cyc(16'h2000, 1'b0, 8'h00, 8'h00);
    st(8'h80);
    for (int i = 0; i < 8; i++) cpu_u.cyc(16'h2000, 1'b1, 8'(8'hA0 + i), 8'h00);
    st(8'h28);
    for (int i = 0; i < 8; i++) ent(16'(16'h00A0 + i));
    te;
    // a then event b
    arm(16'h1234, 16'h2000, 8'h04, 8'h00);
    cpu_u.cyc(16'h2000, 1'b1, 8'h11, 8'h00);
    st(8'h80);
    cpu_u.cyc(16'h1234, 1'b1, 8'h00, 8'h00);
    cpu_u.cyc(16'h2000, 1'b1, 8'h22, 8'h00);
    st(8'hE1);
    te;
    // address and write data byte
    arm(16'h3000, 16'h005A, 8'h05, 8'h04);
    cpu_u.cyc(16'h3000, 1'b0, 8'h5A, 8'h00);
    st(8'h80);
    cpu_u.cyc(16'h3000, 1'b0, 8'h00, 8'h5A);
    st(8'h60);
    te;
    // address and differing read data byte
    arm(16'h3000, 16'h005A, 8'h06, 8'h00);
    cpu_u.cyc(16'h3000, 1'b1, 8'h5A, 8'h00);
    st(8'h80);
    cpu_u.cyc(16'h3000, 1'b1, 8'h5B, 8'h5A);
    st(8'h60);
    te;
    // inside range, upper bound inclusive, just outside either end ignored
    arm(16'h1000, 16'h1FFF, 8'h07, 8'h00);
    cpu_u.cyc(16'h0FFF, 1'b1, 8'h00, 8'h00);
    cpu_u.cyc(16'h2000, 1'b1, 8'h00, 8'h00);
    st(8'h80);
    cpu_u.cyc(16'h1FFF, 1'b1, 8'h00, 8'h00);
    st(8'h60);
    te;
    // outside range, each side sets its own flag
    arm(16'h1000, 16'h1FFF, 8'h08, 8'h00);
    cpu_u.cyc(16'h1000, 1'b1, 8'h00, 8'h00);
    st(8'h80);
    cpu_u.cyc(16'h0FFF, 1'b1, 8'h00, 8'h00);
    st(8'h40);
    arm(16'h1000, 16'h1FFF, 8'h08, 8'h00);
    cpu_u.cyc(16'h2000, 1'b1, 8'h00, 8'h00);
    st(8'h20);
    te;
    // unused code never triggers; manual stop by arm or enable
    arm(16'h1234, 16'h1234, 8'h09, 8'h00);
    cpu_u.cyc(16'h1234, 1'b1, 8'h00, 8'h00);
    st(8'h80);
    apb(1'b1, OFS_CTRL, 32'h00000040);
    st(8'h00);
    arm(16'h1234, 16'h1234, 8'h09, 8'h00);
    apb(1'b1, OFS_CTRL, 32'h00000080);
    st(8'h00);
    te;
    // opcode qualified: trigger only when the tag leaves the pipe
    arm(16'h1234, 16'h0000, 8'h80, 8'h00);
    cpu_u.cyc(16'h1234, 1'b1, 8'h00, 8'h00);
    for (int i = 0; i < PD - 1; i++) cpu_u.adv;
    st(8'h80);
    cpu_u.adv;
    st(8'h40);
    st(8'h40);
    arm(16'h1234, 16'h0000, 8'h80, 8'h00);
    st(8'h80);
    // a flushed tag never reaches the pipe end
    cpu_u.cyc(16'h1234, 1'b1, 8'h00, 8'h00);
    @(posedge clk) fl <= 1'b1;
    @(posedge clk) fl <= 1'b0;
    repeat (PD) cpu_u.adv;
    st(8'h80);
    te;
    end_of_test;
  end
endmodule
